/* File: common/rsw_regs.svh */
// Register map, field positions and timing counts for the reset and watchdog block.
// Assumes a 32-bit classic Wishbone slave, word registers, byte addresses.
`ifndef RSW_REGS_SVH
`define RSW_REGS_SVH
`define RSW_ADR_W 16
`define RSW_SERVICE_ADR 16'h1ff0
`define RSW_CTRL_ADR 16'h0100
`define RSW_STAT_ADR 16'h0104
`define RSW_CNT_ADR 16'h0108
`define RSW_CLEAR_BIT 0
`define RSW_POR_CYCLES 13'h0fe0
`define RSW_POR_W 13
`define RSW_WDG_TIMEOUT 32'h00040000
`define RSW_WDG_W 32
`define RSW_ILL_LO 13'h0130
`define RSW_ILL_HI 13'h0aff
`define RSW_IO_HI 13'h002f
`define RSW_FETCH_W 13
`define RSW_STAT_W 8
`endif

/* File: common/rsw_pkg.sv */
// Types shared by the reset and watchdog block.
// Assumes rsw_regs.svh is included by the design files.
package rsw_pkg;
  typedef enum logic [1:0] {RSW_IDLE, RSW_POR, RSW_HOLD, RSW_RUN} rsw_phase_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [15:0] adr;
    logic [31:0] dat;
  } rsw_wb_req_t;
  typedef struct packed {
    logic [2:0] pin_sync;
    logic pin_low;
    logic ext_active;
    logic ext_done;
    logic wdg_fire;
    logic wdg_done;
    logic ill_fire;
    logic mode_strobe;
    logic [7:0] cause;
    logic ack;
    logic [31:0] rdat;
  } rsw_state_t;
endpackage

/* File: src/rsw_wdog.sv */
// Watchdog counter with power-up hold and halt freeze.
// Assumes the parent gives a one-cycle service pulse and halt level.
`timescale 1ns/100ps
`include "rsw_regs.svh"
module rsw_wdog import rsw_pkg::*; #(
  parameter logic [31:0] TIMEOUT = `RSW_WDG_TIMEOUT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic hold,
  input wire logic halted,
  input wire logic service,
  output logic fire,
  output logic [31:0] count
);
  typedef struct packed {
    logic [31:0] cnt;
    logic fire;
  } rsw_wdog_state_t;
  rsw_wdog_state_t st_reg, st_next;
  always_comb begin
    st_next = st_reg;
    st_next.fire = 1'b0;
    if (!enable || hold || service) begin
      st_next.cnt = 32'h0;
    end else if (halted) begin
      st_next.cnt = st_reg.cnt;
    end else if (st_reg.cnt >= TIMEOUT - 32'h1) begin
      st_next.fire = 1'b1;
      st_next.cnt = 32'h0;
    end else begin
      st_next.cnt = st_reg.cnt + 32'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign fire = st_reg.fire;
  assign count = st_reg.cnt;
  chk_halt_freeze: assert property (@(posedge clk) disable iff (rst)
    enable && halted && !hold && !service |=> count == $past(count)) else
    $error("watchdog moved while halted");
  chk_timeout_fire: assert property (@(posedge clk) disable iff (rst)
    enable && !hold && !halted && !service && count == TIMEOUT - 32'h1 |=> fire) else
    $error("watchdog timeout missed");
endmodule

/* File: src/rsw_top.sv */
// Reset merger, power-up delay, watchdog and illegal-fetch detector.
// Assumes a fetch strobe from the core and an active-low reset pin via open drain.
`timescale 1ns/100ps
`include "rsw_regs.svh"
module rsw_top import rsw_pkg::*; #(
  parameter bit WDG_PRESENT = 1'b1,
  parameter bit STOP_OPTION = 1'b1,
  parameter logic [31:0] WDG_TIMEOUT = `RSW_WDG_TIMEOUT,
  parameter logic [12:0] POR_CYCLES = `RSW_POR_CYCLES,
  parameter logic [7:0] SERVICE_DATA = 8'hff
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Reset pin, open drain
  input wire logic RESET_N_IN,
  output logic RESET_N_OUT,
  output logic RESET_N_OE,
  // Oscillator and core
  input wire logic OSC_ACTIVE,
  input wire logic HALT,
  input wire logic IRQ_WAKE,
  input wire logic FETCH,
  input wire logic [12:0] FETCH_ADR,
  output logic CORE_RST,
  output logic SET_IMASK,
  output logic MODE_SAMPLE,
  // Wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [3:0] SEL_I,
  input wire logic [15:0] ADR_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O
);
  rsw_state_t st_reg, st_next;
  rsw_phase_t ph_reg, ph_next;
  logic [12:0] por_reg, por_next;
  logic halt_reg, halt_next;
  logic wake_rst_reg, wake_rst_next;
  logic [31:0] wdg_count;
  logic wdg_fire;
  logic service;
  logic req;
  logic ill_hit;
  logic any_src;
  rsw_wb_req_t wb;

  assign wb = '{cyc: CYC_I, stb: STB_I, we: WE_I, sel: SEL_I, adr: ADR_I, dat: DAT_I};
  assign req = wb.cyc && wb.stb && !st_reg.ack;
  // Clear needs bit 0 written as zero with its lane enabled
  assign service = req && wb.we && wb.sel[0] && wb.adr == `RSW_SERVICE_ADR
    && !wb.dat[`RSW_CLEAR_BIT];
  assign ill_hit = FETCH && ((FETCH_ADR >= `RSW_ILL_LO && FETCH_ADR <= `RSW_ILL_HI)
    || FETCH_ADR <= `RSW_IO_HI);
  assign any_src = st_reg.pin_low || st_reg.wdg_fire || st_reg.ill_fire;

  rsw_wdog #(
    .TIMEOUT(WDG_TIMEOUT)
  ) u_wdog (
    .clk(CLK),
    .rst(RST),
    .enable(WDG_PRESENT),
    // Only a reset-ended halt or the power-up phase holds the count
    .hold(ph_reg == RSW_POR || ph_reg == RSW_IDLE || wake_rst_reg),
    .halted(halt_reg && STOP_OPTION),
    .service(service),
    .fire(wdg_fire),
    .count(wdg_count)
  );

  always_comb begin
    st_next = st_reg;
    ph_next = ph_reg;
    por_next = por_reg;
    halt_next = halt_reg;
    wake_rst_next = wake_rst_reg;
    st_next.pin_sync = {st_reg.pin_sync[1:0], RESET_N_IN};
    // Change counts only when stages two and three agree
    if (st_reg.pin_sync[2] == st_reg.pin_sync[1]) begin
      st_next.pin_low = !st_reg.pin_sync[2];
    end
    st_next.ext_done = st_reg.pin_low && !st_next.pin_low;
    st_next.wdg_fire = wdg_fire;
    st_next.ill_fire = ill_hit;
    st_next.wdg_done = st_reg.wdg_fire;
    // Ending pin or watchdog reset alone re-samples the mode
    st_next.mode_strobe = (st_reg.ext_done || st_reg.wdg_done) && ph_reg == RSW_RUN;
    if (st_reg.pin_low) begin
      st_next.cause[0] = 1'b1;
    end
    if (st_reg.wdg_fire) begin
      st_next.cause[1] = 1'b1;
    end
    if (st_reg.ill_fire) begin
      st_next.cause[2] = 1'b1;
    end
    if (STOP_OPTION && HALT && ph_reg == RSW_RUN) begin
      halt_next = 1'b1;
    end else if (IRQ_WAKE) begin
      halt_next = 1'b0;
    end
    if (halt_reg && any_src) begin
      halt_next = 1'b0;
      wake_rst_next = 1'b1;
    end
    case (ph_reg)
      RSW_IDLE: begin
        por_next = 13'h0;
        if (OSC_ACTIVE) begin
          ph_next = RSW_POR;
        end
      end
      RSW_POR: begin
        por_next = por_reg + 13'h1;
        if (por_reg >= POR_CYCLES - 13'h1) begin
          ph_next = RSW_HOLD;
        end
      end
      RSW_HOLD: begin
        if (!any_src) begin
          ph_next = RSW_RUN;
        end
      end
      RSW_RUN: begin
        if (wake_rst_reg) begin
          por_next = por_reg + 13'h1;
          if (por_reg >= POR_CYCLES - 13'h1) begin
            wake_rst_next = 1'b0;
          end
        end else begin
          por_next = 13'h0;
        end
      end
      default: begin
        ph_next = RSW_IDLE;
      end
    endcase
    st_next.ack = req;
    st_next.rdat = 32'h0;
    if (req && !wb.we) begin
      case (wb.adr)
        `RSW_SERVICE_ADR: st_next.rdat = {24'h0, SERVICE_DATA};
        `RSW_STAT_ADR: st_next.rdat = {24'h0, st_reg.cause};
        `RSW_CNT_ADR: st_next.rdat = wdg_count;
        `RSW_CTRL_ADR: st_next.rdat = {30'h0, STOP_OPTION, WDG_PRESENT};
        default: st_next.rdat = 32'h0;
      endcase
    end
    // Status is write-one-to-clear; a new cause wins over the clear
    if (req && wb.we && wb.adr == `RSW_STAT_ADR && wb.sel[0]) begin
      st_next.cause = st_reg.cause & ~wb.dat[7:0];
      st_next.cause[0] = st_next.cause[0] | st_reg.pin_low;
      st_next.cause[1] = st_next.cause[1] | st_reg.wdg_fire;
      st_next.cause[2] = st_next.cause[2] | st_reg.ill_fire;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st_reg <= '0;
      ph_reg <= RSW_IDLE;
      por_reg <= 13'h0;
      halt_reg <= 1'b0;
      wake_rst_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      ph_reg <= ph_next;
      por_reg <= por_next;
      halt_reg <= halt_next;
      wake_rst_reg <= wake_rst_next;
    end
  end

  // One merged reset for the core and its interrupt mask
  assign CORE_RST = ph_reg != RSW_RUN || any_src || wake_rst_reg;
  assign SET_IMASK = CORE_RST;
  assign MODE_SAMPLE = st_reg.mode_strobe;
  assign RESET_N_OUT = 1'b0;
  assign RESET_N_OE = ph_reg == RSW_POR || ph_reg == RSW_IDLE;
  assign ACK_O = st_reg.ack;
  assign DAT_O = st_reg.rdat;

  sequence s_pin_release;
    st_reg.pin_low ##1 !st_reg.pin_low;
  endsequence
  chk_pin_holds_reset: assert property (@(posedge CLK) disable iff (RST)
    st_reg.pin_low |-> CORE_RST) else $error("pin low without reset");
  chk_merge_sources: assert property (@(posedge CLK) disable iff (RST)
    st_reg.wdg_fire || st_reg.ill_fire |-> CORE_RST) else $error("source lost");
  chk_exit_start: assert property (@(posedge CLK) disable iff (RST)
    s_pin_release |-> st_reg.ext_done) else $error("exit not started");
  chk_mode_only: assert property (@(posedge CLK) disable iff (RST)
    MODE_SAMPLE |-> $past(st_reg.ext_done || st_reg.wdg_done)) else
    $error("mode sampled by wrong source");
  chk_por_length: assert property (@(posedge CLK) disable iff (RST)
    ph_reg == RSW_POR && por_reg < POR_CYCLES - 13'h1 |=> ph_reg == RSW_POR) else
    $error("power-up delay too short");
  chk_hold_others: assert property (@(posedge CLK) disable iff (RST)
    ph_reg == RSW_HOLD && any_src |=> ph_reg == RSW_HOLD) else
    $error("left hold with source active");
  chk_pin_drive: assert property (@(posedge CLK) disable iff (RST)
    ph_reg == RSW_POR |-> RESET_N_OE && !RESET_N_OUT) else $error("pin not driven");
  chk_wdg_reset: assert property (@(posedge CLK) disable iff (RST)
    wdg_fire |=> CORE_RST) else $error("timeout gave no reset");
  chk_service_clear: assert property (@(posedge CLK) disable iff (RST)
    service && WDG_PRESENT |=> wdg_count == 32'h0) else $error("service ignored");
  chk_service_read: assert property (@(posedge CLK) disable iff (RST)
    req && !wb.we && wb.adr == `RSW_SERVICE_ADR |=> DAT_O == {24'h0, SERVICE_DATA}) else
    $error("service read wrong");
  chk_illegal_fetch: assert property (@(posedge CLK) disable iff (RST)
    FETCH && FETCH_ADR <= `RSW_IO_HI |=> CORE_RST) else $error("illegal fetch missed");
endmodule

/* File: tb/rsw_partner.sv */
// Far-side model: reset pin with pull-up, external reset switch, oscillator.
// Assumes the block pulls the pin low through its open-drain enable.
`timescale 1ns/100ps
module rsw_partner (
  // Clock
  input wire logic clk,
  // Pin and oscillator
  input wire logic oe,
  input wire logic drv,
  input wire logic ext_low,
  output logic pin,
  output logic osc
);
  integer cnt = 0;
  // Pull-up wins unless a party pulls low, so a released pin never floats
  assign pin = (oe ? drv : 1'b1) & ~ext_low;
  // Oscillator starts a few cycles after power-up and then runs on
  always @(posedge clk) if (cnt < 10) cnt <= cnt + 1;
  assign osc = cnt >= 10;
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for rsw_top: bus, power-up, pin, watchdog, fetch.
// Assumes rsw_partner resolves the reset pin and starts the oscillator.
`timescale 1ns/100ps
`include "rsw_regs.svh"
module testbench import rsw_pkg::*; ;
  logic clk = 0, rst = 1, ext_low = 0, halt = 0, wake = 0, fetch = 0, prev = 0;
  logic [12:0] fadr = 0, a;
  logic [31:0] q;
  rsw_wb_req_t req = '0;
  wire logic pin, osc, core_rst, imask, mode, oe, drv, ack;
  wire logic [31:0] rdat;
  integer seed = 32'h4d0073cb, miscompares = 0, n_compared = 0;
  integer n_mode = 0, n_rst = 0, cyc_n = 0, i, n, m, t0;
  logic [15:0] adrs [4] = '{16'h0100, `RSW_SERVICE_ADR, 16'h0200, 16'h0ffc};
  logic [12:0] bnd [6] = '{13'h002f, 13'h0030, 13'h012f, 13'h0130, 13'h0aff, 13'h0b00};
  initial forever #2.5 clk = ~clk;
  rsw_partner u_far (.clk(clk), .oe(oe), .drv(drv), .ext_low(ext_low), .pin(pin), .osc(osc));
  // Short counts keep the run brief; expectations follow these values
  rsw_top #(.WDG_TIMEOUT(32'd64), .POR_CYCLES(13'd16)) u_dut (
    .CLK(clk), .RST(rst), .RESET_N_IN(pin), .RESET_N_OUT(drv), .RESET_N_OE(oe),
    .OSC_ACTIVE(osc), .HALT(halt), .IRQ_WAKE(wake), .FETCH(fetch), .FETCH_ADR(fadr),
    .CORE_RST(core_rst), .SET_IMASK(imask), .MODE_SAMPLE(mode), .CYC_I(req.cyc),
    .STB_I(req.stb), .WE_I(req.we), .SEL_I(req.sel), .ADR_I(req.adr), .DAT_I(req.dat),
    .DAT_O(rdat), .ACK_O(ack));
  function automatic logic [31:0] exp_rd(input logic [15:0] ad);
    return ad == 16'h0100 ? 32'h3 : ad == `RSW_SERVICE_ADR ? 32'hff : 32'h0;
  endfunction
  function automatic logic ill(input logic [12:0] ad);
    return ad <= `RSW_IO_HI || (ad >= `RSW_ILL_LO && ad <= `RSW_ILL_HI);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("mismatches %0d, compares %0d", miscompares, n_compared);
    if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One classic cycle; ack and data are taken at the rising edge, released there too
  task wb(input logic w, input logic [15:0] ad, input logic [31:0] d);
    @(posedge clk) req <= '{1'b1, 1'b1, w, 4'h1, ad, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    req <= '0;
  endtask
  task clr;
    wb(1'b1, `RSW_SERVICE_ADR, 32'h0);
    t0 = cyc_n;
  endtask
  task wait_run;
    n = 0;
    while (core_rst !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
  endtask
  always @(posedge clk) begin
    prev <= core_rst;
    cyc_n++;
    if (mode === 1'b1) n_mode++;
    if (core_rst === 1'b1 && prev === 1'b0) n_rst++;
    if (cyc_n == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  always @(negedge clk) if (!rst) chk(imask, core_rst);
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    wait (osc === 1'b1);
    n = 0;
    while (core_rst !== 1'b0 && n < 100) begin
      @(negedge clk);
      n++;
      if (n <= 16) chk({oe, pin}, 2'b10);
    end
    chk(n >= 16 && n <= 24, 1);
    for (i = 0; i < 4; i++) begin
      wb(1'b1, adrs[i], $random(seed));
      wb(1'b0, adrs[i], 32'h0);
      chk(q, exp_rd(adrs[i]));
    end
    wb(1'b1, `RSW_STAT_ADR, 32'hff);
    m = n_rst;
    for (i = 0; i < 6; i++) begin
      clr;
      repeat (10 + {$random(seed)} % 30) @(posedge clk);
    end
    chk(n_rst - m, 0);
    clr;
    repeat (20) @(posedge clk);
    wb(1'b1, `RSW_SERVICE_ADR, 32'h1);
    m = n_mode;
    while (core_rst !== 1'b1 && cyc_n - t0 < 200) @(negedge clk);
    chk(cyc_n - t0 >= 62 && cyc_n - t0 <= 68, 1);
    wait_run;
    repeat (4) @(posedge clk);
    chk(n_mode - m, 1);
    wb(1'b0, `RSW_STAT_ADR, 32'h0);
    chk(q[1], 1);
    for (i = 0; i < 10; i++) begin
      a = i < 6 ? bnd[i] : $random(seed);
      clr;
      m = n_mode;
      @(posedge clk) begin
        fetch <= 1;
        fadr <= a;
      end
      @(posedge clk) fetch <= 0;
      @(negedge clk) chk(core_rst, ill(a));
      wait_run;
      repeat (4) @(posedge clk);
      chk(n_mode - m, 0);
    end
    clr;
    m = n_mode;
    @(posedge clk) ext_low <= 1;
    repeat (10) @(negedge clk);
    chk(core_rst, 1);
    @(posedge clk) ext_low <= 0;
    wait_run;
    chk(n >= 2 && n <= 6, 1);
    repeat (4) @(posedge clk);
    chk(n_mode - m, 1);
    @(posedge clk) begin
      rst <= 1;
      ext_low <= 1;
    end
    repeat (2) @(posedge clk);
    rst <= 0;
    repeat (40) @(negedge clk);
    chk(core_rst, 1);
    @(posedge clk) ext_low <= 0;
    wait_run;
    chk(n <= 6, 1);
    // Feeding right before halt keeps wake-up cycles from tripping the count
    clr;
    m = n_rst;
    @(posedge clk) halt <= 1;
    repeat (100) @(posedge clk);
    halt <= 0;
    wake <= 1;
    @(posedge clk) wake <= 0;
    clr;
    chk(n_rst - m, 0);
    stop_test();
  end
endmodule
